// *** src/periodic_wakeup_counter.sv ***
// Periodic wakeup counter: APB registers, 8-bit match counter and flag
// Notes on behaviour
// - Flag in status bit 7 sets on the next tick after the count reaches the match limit.
// - Writing one to the flag clears it and its request; zero leaves it.
// - Reset clears flag, clock source, interrupt enable and prescale fields.
// - Bits 6-5 pick source: 00 low-power, 01 external, 1x internal clock.
// - Writing a different clock source clears prescaler and counter.
// - With enable bit 4 set, request follows the flag; otherwise software polls.
// - Prescale bits 3-0 pick ratio; code zero stops the prescaler and counter.
// - Low source bit zero: codes 1-7 binary ratios, 8-15 decimal ratios.
// - Low source bit one: 1024 to 65536 binary, 1000 to 200000 decimal.
// - Writing a different prescale code clears prescaler and counter.
// - Count register reads the live count; writes to it are ignored.
// - Any write to the match limit clears prescaler and counter.
// - On match the count returns to zero and the flag sets.
// - With limit zero, the flag sets on every prescaler tick.
// - Reset sets the match limit and the count to zero.
// - Flag sets on the limit-to-zero step; counting continues from zero.
// - Background debug suspends counting; it resumes from the held value.
// - After reset low-power source selected, prescaler off; nonzero code starts.
//
// Design decisions made here: the APB register port and the register offsets.
`include "wakeup_params.svh"
`default_nettype none
module periodic_wakeup_counter
    import wakeup_pkg::*;
(
    input  wire logic                   pclk,
    input  wire logic                   presetn,
    input  wire logic                   psel,
    input  wire logic                   penable,
    input  wire logic                   pwrite,
    input  wire logic [`ADDR_WIDTH-1:0] paddr,
    input  wire logic [31:0]            pwdata,
    output logic      [31:0]            prdata,
    output logic                        pready,
    output logic                        pslverr,
    input  wire logic                   low_power_osc_clock,
    input  wire logic                   external_ref_clock,
    input  wire logic                   internal_ref_clock,
    input  wire logic                   debug_halt,
    output logic                        match_irq
);
    // Control and status state
    logic             match_flag_reg;
    logic             match_flag_next;
    clock_source_type clock_source_select_reg;
    clock_source_type clock_source_select_next;
    logic             match_irq_enable_reg;
    logic             match_irq_enable_next;
    logic [3:0]       prescale_select_reg;
    logic [3:0]       prescale_select_next;
    logic [7:0]       current_count_reg;
    logic [7:0]       current_count_next;
    logic [7:0]       match_limit_reg;
    logic [7:0]       match_limit_next;
    logic [31:0]      prdata_reg;
    logic [31:0]      prdata_next;

    // Bus decode
    logic             setup_phase;
    logic             access_write;
    logic [1:0]       index;
    logic             mapped;
    logic             wr_status;
    logic             wr_limit;
    logic             wr_count;
    clock_source_type new_source;
    logic [3:0]       new_prescale;

    // Counting path
    logic [2:0]       source_rise;
    logic             source_edge;
    logic             prescale_tick;
    logic             counter_clear;
    logic             count_tick;
    logic             at_limit;
    logic             match_event;

    assign index       = paddr[`INDEX_MSB:`INDEX_LSB];
    // Upper and lower address bits must be zero for a hit
    assign mapped      = (paddr[`ADDR_WIDTH-1:`INDEX_MSB+1] == '0)
                         && (paddr[`INDEX_LSB-1:0] == '0)
                         && (index != 2'h3);
    assign setup_phase  = psel && !penable;
    assign access_write = psel && penable && pwrite && mapped;
    assign wr_status    = access_write && (index == `STATUS_INDEX);
    assign wr_count     = access_write && (index == `COUNT_INDEX);
    assign wr_limit     = access_write && (index == `LIMIT_INDEX);
    assign new_source   = clock_source_type'(pwdata[`CLKSEL_MSB:`CLKSEL_LSB]);
    assign new_prescale = pwdata[`PRESCALE_MSB:`PRESCALE_LSB];

    // Zero wait states keep the bus contract simple
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !mapped;
    assign prdata  = prdata_reg;

    source_edge_sync u_sync (
        .pclk        (pclk),
        .presetn     (presetn),
        .source_raw  ({internal_ref_clock, external_ref_clock, low_power_osc_clock}),
        .source_rise (source_rise)
    );

    always_comb begin
        unique case (clock_source_select_reg)
            src_low_power: source_edge = source_rise[0];
            src_external:  source_edge = source_rise[1];
            src_internal,
            src_internal2: source_edge = source_rise[2];
        endcase
    end

    // Any limit write restarts the chain; a status write only if the source or prescale code changes
    assign counter_clear = wr_limit
        || (wr_status && new_source != clock_source_select_reg)
        || (wr_status && new_prescale != prescale_select_reg);

    prescale_divider u_div (
        .pclk            (pclk),
        .presetn         (presetn),
        .clear           (counter_clear),
        .edge_in         (source_edge && !debug_halt),
        .bank_select     (clock_source_select_reg[0]),
        .prescale_select (prescale_select_reg),
        .tick_out        (prescale_tick)
    );

    // A tick in the cycle of a clear is dropped with the stale count
    assign count_tick  = prescale_tick && !counter_clear;
    assign at_limit    = current_count_reg == match_limit_reg;
    assign match_event = count_tick && at_limit;

    always_comb begin
        current_count_next = current_count_reg;
        if (counter_clear) begin
            current_count_next = `COUNT_RESET;
        end else if (count_tick) begin
            if (at_limit) begin
                current_count_next = `COUNT_RESET;
            end else begin
                current_count_next = current_count_reg + 8'h01;
            end
        end
    end

    always_comb begin
        match_flag_next          = match_flag_reg;
        clock_source_select_next = clock_source_select_reg;
        match_irq_enable_next    = match_irq_enable_reg;
        prescale_select_next     = prescale_select_reg;
        match_limit_next         = match_limit_reg;
        if (wr_status) begin
            clock_source_select_next = new_source;
            match_irq_enable_next    = pwdata[`IRQ_EN_BIT];
            prescale_select_next     = new_prescale;
            if (pwdata[`FLAG_BIT]) begin
                match_flag_next = 1'b0;
            end
        end
        if (wr_limit) begin
            match_limit_next = pwdata[7:0];
        end
        // Set beats a clear in the same cycle so no match is lost
        if (match_event) begin
            match_flag_next = 1'b1;
        end
    end

    // Count register ignores writes; reads sample the live count
    always_comb begin
        prdata_next = prdata_reg;
        if (setup_phase) begin
            prdata_next = '0;
            if (mapped) begin
                unique case (index)
                    `STATUS_INDEX: prdata_next[7:0] = {match_flag_reg, clock_source_select_reg,
                                                      match_irq_enable_reg, prescale_select_reg};
                    `COUNT_INDEX:  prdata_next[7:0] = current_count_reg;
                    `LIMIT_INDEX:  prdata_next[7:0] = match_limit_reg;
                    default:       prdata_next[7:0] = 8'h00;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            match_flag_reg          <= `FLAG_RESET;
            clock_source_select_reg <= src_low_power;
            match_irq_enable_reg    <= `FLAG_RESET;
            prescale_select_reg     <= `PRESCALE_OFF;
            current_count_reg       <= `COUNT_RESET;
            match_limit_reg         <= `LIMIT_RESET;
            prdata_reg              <= '0;
        end else begin
            match_flag_reg          <= match_flag_next;
            clock_source_select_reg <= clock_source_select_next;
            match_irq_enable_reg    <= match_irq_enable_next;
            prescale_select_reg     <= prescale_select_next;
            current_count_reg       <= current_count_next;
            match_limit_reg         <= match_limit_next;
            prdata_reg              <= prdata_next;
        end
    end

    assign match_irq = match_flag_reg && match_irq_enable_reg;

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    a_flag_on_match: assert property (match_event |=> match_flag_reg)
        else $error("flag not set after match");
    a_flag_w1_clear: assert property (wr_status && pwdata[`FLAG_BIT] && !match_event
        |=> !match_flag_reg && !match_irq)
        else $error("flag not cleared by write of one");
    a_flag_w0_keep: assert property (wr_status && !pwdata[`FLAG_BIT] && match_flag_reg
        |=> match_flag_reg)
        else $error("flag lost on write of zero");
    a_reset_fields: assert property ($rose(presetn) |-> match_flag_reg == 1'b0
        && clock_source_select_reg == src_low_power && !match_irq_enable_reg
        && prescale_select_reg == `PRESCALE_OFF)
        else $error("control fields not zero after reset");
    a_source_clear: assert property (wr_status && new_source != clock_source_select_reg
        |=> current_count_reg == `COUNT_RESET && !prescale_tick)
        else $error("source change did not clear count");
    a_irq_level: assert property ($rose(match_flag_reg) && match_irq_enable_reg |-> match_irq
        ##1 (match_irq == (match_flag_reg && match_irq_enable_reg)))
        else $error("interrupt does not follow flag");
    a_prescale_off: assert property (prescale_select_reg == `PRESCALE_OFF
        && $past(prescale_select_reg) == `PRESCALE_OFF && !counter_clear
        |=> $stable(current_count_reg))
        else $error("count moved with prescaler off");
    a_prescale_clear: assert property (wr_status && new_prescale != prescale_select_reg
        |=> current_count_reg == `COUNT_RESET)
        else $error("prescale change did not clear count");
    a_count_readonly: assert property (wr_count && !count_tick
        |=> current_count_reg == $past(current_count_reg))
        else $error("count changed by write");
    a_limit_clear: assert property (wr_limit
        |=> current_count_reg == `COUNT_RESET && match_limit_reg == $past(pwdata[7:0]))
        else $error("limit write did not clear count");
    a_wrap_zero: assert property (count_tick && at_limit
        |=> current_count_reg == `COUNT_RESET && match_flag_reg)
        else $error("no wrap to zero on match");
    a_step_up: assert property (count_tick && !at_limit
        |=> current_count_reg == $past(current_count_reg) + 8'h01)
        else $error("count did not step by one");
    a_debug_hold: assert property (debug_halt && !counter_clear [*2]
        |=> $stable(current_count_reg))
        else $error("count moved in debug");

    c_match_irq: cover property (match_event && match_irq_enable_reg ##1 match_irq);
    c_limit_zero: cover property (match_limit_reg == `LIMIT_RESET && match_event);
    c_debug_hold: cover property (debug_halt && prescale_tick);
    c_bad_addr: cover property (pslverr);
endmodule : periodic_wakeup_counter
`default_nettype wire

// *** src/wakeup_params.svh ***
// Register map, field positions, reset values and divide tables of the wakeup counter
`ifndef WAKEUP_PARAMS_SVH
`define WAKEUP_PARAMS_SVH

`define ADDR_WIDTH      8
`define INDEX_MSB       3
`define INDEX_LSB       2
`define STATUS_INDEX    2'h0
`define COUNT_INDEX     2'h1
`define LIMIT_INDEX     2'h2

`define FLAG_BIT        7
`define CLKSEL_MSB      6
`define CLKSEL_LSB      5
`define IRQ_EN_BIT      4
`define PRESCALE_MSB    3
`define PRESCALE_LSB    0

`define FLAG_RESET      1'b0
`define COUNT_RESET     8'h00
`define LIMIT_RESET     8'h00
`define PRESCALE_OFF    4'h0
`define DIV_WIDTH       18
`define DIV_ZERO        18'h00000
`define DIV_ONE         18'h00001

// Entries for codes 15 down to 0, one 18-bit ratio each, 0 means off
`define DIV_TABLE_LOW  {18'd1000, 18'd500, 18'd100, 18'd16, 18'd10, 18'd4, 18'd2, 18'd1, \
                        18'd1024, 18'd512, 18'd256, 18'd128, 18'd64, 18'd32, 18'd8, 18'd0}
`define DIV_TABLE_HIGH {18'd200000, 18'd100000, 18'd50000, 18'd20000, 18'd10000, 18'd5000, \
                        18'd2000, 18'd1000, 18'd65536, 18'd32768, 18'd16384, 18'd8192, \
                        18'd4096, 18'd2048, 18'd1024, 18'd0}

`endif

// *** src/wakeup_pkg.sv ***
// Types shared by the wakeup counter modules
`default_nettype none
package wakeup_pkg;
    typedef enum logic [1:0] {
        src_low_power = 2'b00,
        src_external  = 2'b01,
        src_internal  = 2'b10,
        src_internal2 = 2'b11
    } clock_source_type;
    typedef logic [17:0] ratio_type;
endpackage : wakeup_pkg
`default_nettype wire

// *** src/source_edge_sync.sv ***
// Two-flop synchronisers and rising-edge pulses for the three clock sources
`default_nettype none
module source_edge_sync (
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic [2:0] source_raw,
    output logic      [2:0] source_rise
);
    logic [2:0] meta_reg;
    logic [2:0] meta_next;
    logic [2:0] sync_reg;
    logic [2:0] sync_next;
    logic [2:0] prev_reg;
    logic [2:0] prev_next;

    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1) begin : g_src
            // Edge taken from the second stage against the third
            always_comb begin
                meta_next[i] = source_raw[i];
                sync_next[i] = meta_reg[i];
                prev_next[i] = sync_reg[i];
            end
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    meta_reg[i] <= 1'b0;
                    sync_reg[i] <= 1'b0;
                    prev_reg[i] <= 1'b0;
                end else begin
                    meta_reg[i] <= meta_next[i];
                    sync_reg[i] <= sync_next[i];
                    prev_reg[i] <= prev_next[i];
                end
            end
            assign source_rise[i] = sync_reg[i] & ~prev_reg[i];
        end
    endgenerate
endmodule : source_edge_sync
`default_nettype wire

// *** src/prescale_divider.sv ***
// Prescaler: counts source edges and pulses once per selected ratio
`include "wakeup_params.svh"
`default_nettype none
module prescale_divider
    import wakeup_pkg::*;
(
    input  wire logic       pclk,
    input  wire logic       presetn,
    input  wire logic       clear,
    input  wire logic       edge_in,
    input  wire logic       bank_select,
    input  wire logic [3:0] prescale_select,
    output logic            tick_out
);
    localparam logic [16*`DIV_WIDTH-1:0] table_low  = `DIV_TABLE_LOW;
    localparam logic [16*`DIV_WIDTH-1:0] table_high = `DIV_TABLE_HIGH;

    ratio_type ratio;
    ratio_type div_reg;
    ratio_type div_next;
    logic      tick_reg;
    logic      tick_next;

    always_comb begin
        if (bank_select) begin
            ratio = table_high[prescale_select*`DIV_WIDTH +: `DIV_WIDTH];
        end else begin
            ratio = table_low[prescale_select*`DIV_WIDTH +: `DIV_WIDTH];
        end
    end

    always_comb begin
        div_next  = div_reg;
        tick_next = 1'b0;
        if (clear) begin
            div_next = `DIV_ZERO;
        end else if (edge_in && ratio != `DIV_ZERO) begin
            if (div_reg >= ratio - `DIV_ONE) begin
                div_next  = `DIV_ZERO;
                tick_next = 1'b1;
            end else begin
                div_next = div_reg + `DIV_ONE;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_reg  <= `DIV_ZERO;
            tick_reg <= 1'b0;
        end else begin
            div_reg  <= div_next;
            tick_reg <= tick_next;
        end
    end

    assign tick_out = tick_reg;
endmodule : prescale_divider
`default_nettype wire

// *** testbench/periodic_wakeup_counter_test.sv ***
// Self-checking bench for the periodic wakeup counter
`default_nettype none
module periodic_wakeup_counter_test;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int lo_div_table[16] = '{0, 8, 32, 64, 128, 256, 512, 1024,
                                        1, 2, 4, 10, 16, 100, 500, 1000};
    localparam int hi_div_table[16] = '{0, 1024, 2048, 4096, 8192, 16384, 32768, 65536,
                                        1000, 2000, 5000, 10000, 20000, 50000, 100000, 200000};

    logic        pclk;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [2:0]  src_pins;
    logic        debug_halt;
    logic        match_irq;
    logic [31:0] rd;
    logic        err;
    int          errors;
    int          checks;

    periodic_wakeup_counter u_periodic_wakeup_counter (
        .pclk                (pclk),
        .presetn             (presetn),
        .psel                (psel),
        .penable             (penable),
        .pwrite              (pwrite),
        .paddr               (paddr),
        .pwdata              (pwdata),
        .prdata              (prdata),
        .pready              (pready),
        .pslverr             (pslverr),
        .low_power_osc_clock (src_pins[0]),
        .external_ref_clock  (src_pins[1]),
        .internal_ref_clock  (src_pins[2]),
        .debug_halt          (debug_halt),
        .match_irq           (match_irq)
    );

    function automatic int div_of(input logic [1:0] s, input int code);
        return s[0] ? hi_div_table[code] : lo_div_table[code];
    endfunction : div_of

    function automatic int pin_of(input logic [1:0] s);
        return s[1] ? 2 : (s[0] ? 1 : 0);
    endfunction : pin_of

    function automatic logic [31:0] stat(input logic f, input logic [1:0] s, input logic ie,
                                         input logic [3:0] ps);
        return {24'h000000, f, s, ie, ps};
    endfunction : stat

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, seen, exp);
        end
    endtask : chk

    // Request held until pready is sampled high; data taken at that edge
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge pclk);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        rd  = prdata;
        err = pslverr;
        if (n >= 50) chk(1'b0, 1'b1, "pready wait");
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp, "register read");
    endtask : rdchk

    // Each source level held 2 cycles, one more than the synchroniser needs to see it
    task automatic edges(input int pin, input int n);
        repeat (n) begin
            @(posedge pclk);
            src_pins[pin] <= 1'b1;
            repeat (2) @(posedge pclk);
            src_pins[pin] <= 1'b0;
            @(posedge pclk);
        end
        repeat (8) @(posedge pclk);
    endtask : edges

    // Limit write last so divider and count start from zero
    task automatic setup(input logic [1:0] s, input logic ie, input logic [3:0] ps,
                         input logic [7:0] lim);
        apb(1'b1, 8'h00, stat(1'b1, s, ie, ps));
        apb(1'b1, 8'h08, {24'h0, lim});
    endtask : setup

    task automatic ratio_chk(input logic [1:0] s, input int code);
        int d;
        d = div_of(s, code);
        setup(s, 1'b0, code[3:0], 8'hff);
        edges(pin_of(s), d - 1);
        rdchk(8'h04, 32'h0);
        edges(pin_of(s), 1);
        rdchk(8'h04, 32'h1);
    endtask : ratio_chk

    task final_report;
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report

    initial begin
        pclk = 1'b0;
        forever #4 pclk = ~pclk;
    end

    // Tests need roughly 25k cycles
    initial begin
        repeat (90000) @(posedge pclk);
        errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        final_report;
    end

    initial begin
        int n, lim, code, t;
        logic [1:0] s;
        presetn    = 1'b0;
        psel       = 1'b0;
        penable    = 1'b0;
        pwrite     = 1'b0;
        paddr      = 8'h00;
        pwdata     = 32'h0;
        src_pins   = 3'h0;
        debug_halt = 1'b0;
        errors     = 0;
        checks     = 0;
        void'($urandom(26381));
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        rdchk(8'h00, 32'h0);
        rdchk(8'h04, 32'h0);
        rdchk(8'h08, 32'h0);
        chk(match_irq, 1'b0, "irq after reset");
        edges(0, 5);
        rdchk(8'h04, 32'h0);
        $display("reset test done");
        n = $urandom_range(255);
        apb(1'b1, 8'h08, n);
        rdchk(8'h08, n);
        apb(1'b1, 8'h04, $urandom);
        rdchk(8'h04, 32'h0);
        apb(1'b0, 8'h0c, 32'h0);
        chk(err, 1'b1, "unmapped error");
        chk(rd, 32'h0, "unmapped data");
        $display("register test done");
        for (int c = 1; c < 16; c++) ratio_chk(2'b00, c);
        ratio_chk(2'b01, 1);
        ratio_chk(2'b11, 8);
        $display("ratio test done");
        setup(2'b10, 1'b1, 4'h8, 8'h02);
        edges(2, 2);
        rdchk(8'h04, 32'h2);
        rdchk(8'h00, stat(1'b0, 2'b10, 1'b1, 4'h8));
        chk(match_irq, 1'b0, "irq before match");
        edges(2, 1);
        rdchk(8'h04, 32'h0);
        rdchk(8'h00, stat(1'b1, 2'b10, 1'b1, 4'h8));
        chk(match_irq, 1'b1, "irq on match");
        apb(1'b1, 8'h00, stat(1'b0, 2'b10, 1'b1, 4'h8));
        rdchk(8'h00, stat(1'b1, 2'b10, 1'b1, 4'h8));
        apb(1'b1, 8'h00, stat(1'b1, 2'b10, 1'b1, 4'h8));
        rdchk(8'h00, stat(1'b0, 2'b10, 1'b1, 4'h8));
        chk(match_irq, 1'b0, "irq after clear");
        apb(1'b1, 8'h00, stat(1'b0, 2'b10, 1'b0, 4'h8));
        edges(2, 3);
        rdchk(8'h00, stat(1'b1, 2'b10, 1'b0, 4'h8));
        chk(match_irq, 1'b0, "irq disabled");
        $display("match test done");
        setup(2'b10, 1'b1, 4'h8, 8'h00);
        edges(2, 1);
        rdchk(8'h00, stat(1'b1, 2'b10, 1'b1, 4'h8));
        rdchk(8'h04, 32'h0);
        apb(1'b1, 8'h00, stat(1'b1, 2'b10, 1'b1, 4'h8));
        edges(2, 1);
        rdchk(8'h00, stat(1'b1, 2'b10, 1'b1, 4'h8));
        $display("zero limit test done");
        setup(2'b10, 1'b0, 4'h8, 8'd200);
        edges(2, 5);
        rdchk(8'h04, 32'h5);
        apb(1'b1, 8'h00, stat(1'b1, 2'b10, 1'b0, 4'h9));
        rdchk(8'h04, 32'h0);
        edges(2, 3);
        rdchk(8'h04, 32'h1);
        apb(1'b1, 8'h00, stat(1'b1, 2'b00, 1'b0, 4'h9));
        rdchk(8'h04, 32'h0);
        edges(2, 4);
        rdchk(8'h04, 32'h0);
        edges(0, 1);
        apb(1'b1, 8'h08, 32'd200);
        edges(0, 1);
        rdchk(8'h04, 32'h0);
        edges(0, 1);
        rdchk(8'h04, 32'h1);
        $display("clear test done");
        setup(2'b10, 1'b0, 4'h8, 8'hff);
        edges(2, 3);
        debug_halt <= 1'b1;
        edges(2, 4);
        rdchk(8'h04, 32'h3);
        debug_halt <= 1'b0;
        edges(2, 2);
        rdchk(8'h04, 32'h5);
        $display("debug test done");
        repeat (8) begin
            s    = $urandom_range(1) ? 2'b10 : 2'b00;
            code = $urandom_range(10, 8);
            lim  = $urandom_range(15, 1);
            n    = $urandom_range(40);
            setup(s, 1'b0, code[3:0], lim[7:0]);
            edges(pin_of(s), n);
            t = n / div_of(s, code);
            rdchk(8'h04, t % (lim + 1));
            rdchk(8'h00, stat(t > lim, s, 1'b0, code[3:0]));
        end
        $display("random test done");
        final_report;
    end
endmodule : periodic_wakeup_counter_test
`default_nettype wire
